// ### hdl/ifcp_port.v
`timescale 1ns/10ps
`include "ifcp_defs.vh"
module ifcp_port #(
  parameter ADDR_MODE = `IFCP_MODE_PINS,
  parameter [3:0] FACTORY_CODE = 4'h0,
  parameter [3:0] RANGE_RST = 4'h0,
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2,
  parameter [11:0] DELAY_CYC = `IFCP_PULL_DELAY_CYC,
  parameter [11:0] SETTLE_CYC = `IFCP_PULL_SETTLE_CYC
) (
  input wire core_clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire addr_sel_hi_pin,
  input wire addr_sel_lo_pin,
  output wire scl_out,
  output wire scl_oe_n,
  output wire sda_out,
  output wire sda_oe_n,
  output wire [25:0] pull_value_word,
  output wire [3:0] pull_range,
  output wire pull_start,
  output wire pull_pending,
  output wire pull_settling
);
  localparam [2:0] S_IDLE = 3'h0, S_ADDR = 3'h1, S_PTR = 3'h2;
  localparam [2:0] S_WR = 3'h3, S_RD = 3'h4, S_WAIT = 3'h5;
  localparam [1:0] W_PTR = 2'h0, W_DATA = 2'h1, W_READ = 2'h2;

  function [6:0] dev_addr;
    input [1:0] sel;
    begin
      if (ADDR_MODE == `IFCP_MODE_FACTORY) begin
        dev_addr = {`IFCP_ADDR_BASE, FACTORY_CODE};
      end else begin
        dev_addr = {`IFCP_ADDR_BASE, sel[1], 1'b0, sel[0], 1'b0};
      end
    end
  endfunction

  function [15:0] reg_read;
    input [7:0] a;
    input [15:0] lo;
    input [9:0] hi;
    input [3:0] rng;
    begin
      if (a == `IFCP_REG_LOWER) begin
        reg_read = lo;
      end else if (a == `IFCP_REG_UPPER) begin
        reg_read = {6'h00, hi};
      end else if (a == `IFCP_REG_RANGE) begin
        reg_read = {12'h000, rng};
      end else begin
        reg_read = 16'h0000;
      end
    end
  endfunction

  wire scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  wire [1:0] sel_s;
  reg scl_d_reg, sda_d_reg;

  // both lines filtered so a glitch cannot fake a start or stop
  ifcp_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );
  ifcp_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .async_in({addr_sel_hi_pin, addr_sel_lo_pin}),
    .sync_out(sel_s)
  );

  // a 1 us bus bit still spans about 25 core cycles after filtering
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  reg [2:0] st_reg;
  reg [3:0] bitcnt_reg, range_reg;
  reg [7:0] shift_reg, tx_reg, ptr_reg, hi_byte_reg;
  reg [15:0] rd_word_reg, lower_reg;
  reg [9:0] upper_reg;
  reg [1:0] wait_kind_reg;
  reg [8:0] push_data_reg;
  reg [11:0] dcnt_reg, scnt_reg;
  reg [25:0] pull_word_reg;
  reg rd_lo_reg, ack_reg, own_ack_reg, push_valid_reg, rd_inc_reg;
  reg sda_oe_n_reg, scl_oe_n_reg, sda_out_reg, scl_out_reg;
  reg hi_valid_reg, pend_reg, settle_reg, pull_start_reg;
  wire fifo_in_ready, fifo_out_valid, pop;
  wire [8:0] fifo_out_data;
  wire [15:0] cur_word;
  wire [7:0] next_tx;

  assign cur_word = reg_read(ptr_reg, lower_reg, upper_reg, range_reg);
  assign next_tx = {tx_reg[6:0], 1'b0};
  // committer stalls while a pull is queued, so the fifo can fill
  assign pop = fifo_out_valid & ~pend_reg;

  ifcp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .in_valid(push_valid_reg), .in_data(push_data_reg),
    .in_ready(fifo_in_ready), .out_valid(fifo_out_valid),
    .out_data(fifo_out_data), .out_ready(~pend_reg)
  );

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg <= S_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rd_word_reg <= 16'h0000;
      rd_lo_reg <= 1'b0;
      ack_reg <= 1'b0;
      own_ack_reg <= 1'b0;
      wait_kind_reg <= W_PTR;
      push_valid_reg <= 1'b0;
      push_data_reg <= 9'h000;
      rd_inc_reg <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      scl_oe_n_reg <= 1'b1;
      sda_out_reg <= 1'b0;
      scl_out_reg <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      push_valid_reg <= 1'b0;
      rd_inc_reg <= 1'b0;
      if (bus_start) begin
        st_reg <= S_ADDR;
        bitcnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        sda_oe_n_reg <= 1'b1;
      end else if (bus_stop) begin
        st_reg <= S_IDLE;
        ack_reg <= 1'b0;
        sda_oe_n_reg <= 1'b1;
      end else begin
        case (st_reg)
          S_ADDR, S_PTR, S_WR: begin
            // clock let go a cycle after the ack, so data leads the clock
            scl_oe_n_reg <= 1'b1;
            if (scl_rise && !ack_reg) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end else if (scl_fall && ack_reg) begin
              ack_reg <= 1'b0;
              sda_oe_n_reg <= 1'b1;
              bitcnt_reg <= 4'h0;
            end else if (scl_fall && bitcnt_reg == 4'h8) begin
              if (st_reg == S_ADDR) begin
                if (shift_reg[7:1] != dev_addr(sel_s)) begin
                  st_reg <= S_IDLE;
                end else if (shift_reg[0]) begin
                  st_reg <= S_WAIT;
                  wait_kind_reg <= W_READ;
                end else begin
                  st_reg <= S_PTR;
                  ack_reg <= 1'b1;
                  own_ack_reg <= 1'b1;
                  sda_oe_n_reg <= 1'b0;
                end
              end else begin
                st_reg <= S_WAIT;
                wait_kind_reg <= (st_reg == S_PTR) ? W_PTR : W_DATA;
              end
            end
          end
          S_WAIT: begin
            // clock held low while the byte cannot be taken or served
            if (wait_kind_reg == W_READ) begin
              if (!fifo_out_valid && !push_valid_reg) begin
                st_reg <= S_RD;
                rd_lo_reg <= 1'b0;
                ack_reg <= 1'b1;
                own_ack_reg <= 1'b1;
                sda_oe_n_reg <= 1'b0;
              end else begin
                scl_oe_n_reg <= 1'b0;
              end
            end else if (fifo_in_ready) begin
              push_valid_reg <= 1'b1;
              push_data_reg <= {wait_kind_reg == W_PTR, shift_reg};
              st_reg <= S_WR;
              ack_reg <= 1'b1;
              own_ack_reg <= 1'b1;
              sda_oe_n_reg <= 1'b0;
            end else begin
              scl_oe_n_reg <= 1'b0;
            end
          end
          S_RD: begin
            scl_oe_n_reg <= 1'b1;
            if (scl_rise && ack_reg && !own_ack_reg) begin
              if (!sda_s) begin
                st_reg <= S_IDLE;
              end else begin
                rd_lo_reg <= ~rd_lo_reg;
                rd_inc_reg <= rd_lo_reg;
              end
            end else if (scl_rise && !ack_reg) begin
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end else if (scl_fall && ack_reg) begin
              ack_reg <= 1'b0;
              own_ack_reg <= 1'b0;
              bitcnt_reg <= 4'h0;
              if (rd_lo_reg) begin
                tx_reg <= rd_word_reg[7:0];
                sda_oe_n_reg <= rd_word_reg[7];
              end else begin
                tx_reg <= cur_word[15:8];
                rd_word_reg <= cur_word;
                sda_oe_n_reg <= cur_word[15];
              end
            end else if (scl_fall && bitcnt_reg == 4'h8) begin
              ack_reg <= 1'b1;
              sda_oe_n_reg <= 1'b1;
            end else if (scl_fall) begin
              tx_reg <= next_tx;
              sda_oe_n_reg <= next_tx[7];
            end
          end
          default: begin
            ack_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // committer: pairs bytes into words and owns the pointer
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_reg <= `IFCP_PTR_RST;
      lower_reg <= `IFCP_LOWER_RST;
      upper_reg <= `IFCP_UPPER_RST;
      range_reg <= RANGE_RST;
      hi_byte_reg <= 8'h00;
      hi_valid_reg <= 1'b0;
      pend_reg <= 1'b0;
      dcnt_reg <= 12'h000;
      settle_reg <= 1'b0;
      scnt_reg <= 12'h000;
      pull_start_reg <= 1'b0;
      pull_word_reg <= 26'h0000000;
    end else begin
      pull_start_reg <= 1'b0;
      if (pop) begin
        if (fifo_out_data[8]) begin
          ptr_reg <= fifo_out_data[7:0];
          hi_valid_reg <= 1'b0;
        end else if (!hi_valid_reg) begin
          hi_byte_reg <= fifo_out_data[7:0];
          hi_valid_reg <= 1'b1;
        end else begin
          hi_valid_reg <= 1'b0;
          ptr_reg <= ptr_reg + 8'h01;
          if (ptr_reg == `IFCP_REG_LOWER) begin
            lower_reg <= {hi_byte_reg, fifo_out_data[7:0]};
          end else if (ptr_reg == `IFCP_REG_UPPER) begin
            upper_reg <= {hi_byte_reg[1:0], fifo_out_data[7:0]};
            pend_reg <= 1'b1;
            dcnt_reg <= 12'h000;
          end else if (ptr_reg == `IFCP_REG_RANGE) begin
            range_reg <= fifo_out_data[3:0];
          end
        end
      end else if (rd_inc_reg) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
      if (pend_reg) begin
        if (dcnt_reg == DELAY_CYC - 12'h001) begin
          pend_reg <= 1'b0;
          pull_start_reg <= 1'b1;
          pull_word_reg <= {upper_reg, lower_reg};
          settle_reg <= 1'b1;
          scnt_reg <= 12'h000;
        end else begin
          dcnt_reg <= dcnt_reg + 12'h001;
        end
      end
      if (settle_reg && !pull_start_reg) begin
        if (scnt_reg == SETTLE_CYC - 12'h001) begin
          settle_reg <= 1'b0;
        end else begin
          scnt_reg <= scnt_reg + 12'h001;
        end
      end
    end
  end

  assign scl_out = scl_out_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_out = sda_out_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign pull_value_word = pull_word_reg;
  assign pull_range = range_reg;
  assign pull_start = pull_start_reg;
  assign pull_pending = pend_reg;
  assign pull_settling = settle_reg;
endmodule

// ### shared/ifcp_defs.vh
`ifndef IFCP_DEFS_VH
`define IFCP_DEFS_VH

// register pointer values
`define IFCP_REG_LOWER 8'h00
`define IFCP_REG_UPPER 8'h01
`define IFCP_REG_RANGE 8'h02

// field widths
`define IFCP_UPPER_W 10
`define IFCP_RANGE_W 4

// reset values
`define IFCP_LOWER_RST 16'h0000
`define IFCP_UPPER_RST 10'h000
`define IFCP_PTR_RST 8'h00

// device address: fixed upper three bits
`define IFCP_ADDR_BASE 3'h6

// address modes
`define IFCP_MODE_FACTORY 1'b0
`define IFCP_MODE_PINS 1'b1

// timing
`define IFCP_CLK_MHZ 25
`define IFCP_PULL_DELAY_US 103
`define IFCP_PULL_SETTLE_US 20
`define IFCP_PULL_DELAY_CYC (`IFCP_PULL_DELAY_US * `IFCP_CLK_MHZ)
`define IFCP_PULL_SETTLE_CYC (`IFCP_PULL_SETTLE_US * `IFCP_CLK_MHZ)

`endif

// ### hdl/ifcp_sync.v
`timescale 1ns/10ps
module ifcp_sync #(
  parameter WIDTH = 2,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
  input wire core_clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  reg [WIDTH-1:0] out_reg;
  wire [WIDTH-1:0] agree;

  // a bit only moves once the second and third stages agree
  assign agree = ~(s2_reg ^ s3_reg);
  assign sync_out = out_reg;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      out_reg <= RST_VAL;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= (agree & s3_reg) | (~agree & out_reg);
    end
  end
endmodule

// ### hdl/ifcp_fifo.v
`timescale 1ns/10ps
module ifcp_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire core_clk,
  input wire sys_rst,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [WIDTH-1:0] out_data,
  input wire out_ready
);
  // depth must be a power of two: pointers wrap by overflow
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] cnt_reg;
  wire do_push;
  wire do_pop;

  assign in_ready = (cnt_reg != FULL_CNT);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rptr_reg];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (do_push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ### test/ifcp_port_sva.sv
`timescale 1ns/10ps
module ifcp_port_sva #(
  parameter [11:0] DELAY_CYC = 12'h014,
  parameter [11:0] SETTLE_CYC = 12'h00a
) (
  input logic core_clk,
  input logic sys_rst,
  input logic scl_in,
  input logic scl_oe_n,
  input logic sda_oe_n,
  input logic [25:0] pull_value_word,
  input logic pull_start,
  input logic pull_pending,
  input logic pull_settling
);
  logic [12:0] pend_cnt_reg;
  logic [12:0] set_cnt_reg;
  // the delay figures exceed what a repetition can hold, so count them
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_cnt_reg <= 13'h0000;
      set_cnt_reg <= 13'h0000;
    end else begin
      pend_cnt_reg <= pull_pending ? pend_cnt_reg + 13'h0001 : 13'h0000;
      set_cnt_reg <= pull_settling ? set_cnt_reg + 13'h0001 : 13'h0000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_pulse_single: assert property (pull_start |=> !pull_start)
    else $error("pull start longer than one cycle");
  chk_pend_bound: assert property (pend_cnt_reg <= DELAY_CYC + 13'h0001)
    else $error("pull delay overran");
  chk_wait_full: assert property (
    pull_start |-> pend_cnt_reg + 13'h0001 >= DELAY_CYC)
    else $error("pull started early");
  chk_start_needs_pend: assert property (
    pull_start |-> $past(pull_pending))
    else $error("pull without committed upper word");
  chk_pend_exit: assert property (
    $fell(pull_pending) |-> pull_start || $past(pull_start))
    else $error("pending dropped without pull");
  chk_word_hold: assert property (
    $changed(pull_value_word) |-> pull_start)
    else $error("pull value moved outside a pull");
  chk_settle_on: assert property (pull_start |-> ##[0:1] pull_settling)
    else $error("settling not flagged");
  chk_settle_len: assert property (
    $fell(pull_settling) |-> set_cnt_reg >= SETTLE_CYC)
    else $error("settling too short");
  chk_sda_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("data changed while clock high");
  chk_stretch_low: assert property (
    $fell(scl_oe_n) |-> !$past(scl_in))
    else $error("clock held while high");
endmodule
bind ifcp_port ifcp_port_sva #(.DELAY_CYC(DELAY_CYC),
  .SETTLE_CYC(SETTLE_CYC)) u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
  .pull_value_word(pull_value_word), .pull_start(pull_start),
  .pull_pending(pull_pending), .pull_settling(pull_settling));

// ### test/ifcp_tb_master.sv
`timescale 1ns/10ps
module ifcp_tb_master #(
  parameter int TQ = 160
) (
  input wire scl_w,
  input wire sda_w,
  output logic scl_m,
  output logic sda_m,
  output logic res_stb,
  output logic [8:0] res_val,
  output logic stuck
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    res_stb = 1'b0;
    res_val = 9'h000;
    stuck = 1'b0;
  end
  // honours clock stretching, but a held clock must not hang the run
  task automatic rise;
    int n;
    n = 0;
    scl_m = 1'b1;
    while (scl_w !== 1'b1 && n < 4000) begin
      #10;
      n++;
    end
    if (n >= 4000)
      stuck = 1'b1;
  endtask
  // data moves mid low phase, sampled late in the high phase
  task automatic clk_bit(input logic b, output logic s);
    #(2*TQ) sda_m = b;
    #(2*TQ) rise();
    #(2*TQ) s = sda_w;
    scl_m = 1'b0;
  endtask
  task automatic start;
    #(2*TQ) sda_m = 1'b1;
    #(2*TQ) rise();
    #(2*TQ) sda_m = 1'b0;
    #(2*TQ) scl_m = 1'b0;
  endtask
  task automatic stop;
    #(2*TQ) sda_m = 1'b0;
    #(2*TQ) rise();
    #(2*TQ) sda_m = 1'b1;
    #(4*TQ);
  endtask
  task automatic report(input logic [8:0] v);
    res_val = v;
    res_stb = ~res_stb;
  endtask
  task automatic send(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], s);
    clk_bit(1'b1, s);
    report({1'b1, 7'h00, s});
  endtask
  task automatic recv(input logic mack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(mack, s);
    report({1'b0, d});
  endtask
endmodule

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sel_hi = 1'b1;
  logic sel_lo = 1'b1;
  logic scl_m, sda_m, res_stb, stuck, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic pull_start, pull_pending, pull_settling;
  logic [8:0] res_val;
  logic [25:0] pull_value_word;
  logic [3:0] pull_range;
  logic [31:0] lfsr = 32'h0000cc2f;
  logic [31:0] expq[$];
  logic [25:0] pullq[$];
  int mismatches = 0;
  int comparisons = 0;
  // open drain: whoever pulls low wins, the pull-ups give the idle high
  wire scl_w = scl_m & (scl_oe_n | scl_out);
  wire sda_w = sda_m & (sda_oe_n | sda_out);
  always #20 core_clk = ~core_clk;
  ifcp_port #(.DELAY_CYC(12'h4b0), .SETTLE_CYC(12'h00a)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_w), .sda_in(sda_w),
    .addr_sel_hi_pin(sel_hi), .addr_sel_lo_pin(sel_lo),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .pull_value_word(pull_value_word),
    .pull_range(pull_range), .pull_start(pull_start),
    .pull_pending(pull_pending), .pull_settling(pull_settling));
  ifcp_tb_master u_master (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
    .sda_m(sda_m), .res_stb(res_stb), .res_val(res_val), .stuck(stuck));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic ex(input logic [8:0] v);
    expq.push_back({23'h000000, v});
  endtask
  task automatic xw(input logic [6:0] a, input logic [7:0] ptr, input int n,
                    input logic [127:0] d, input logic stp);
    u_master.start();
    ex(9'h100);
    u_master.send({a, 1'b0});
    ex(9'h100);
    u_master.send(ptr);
    for (int i = n - 1; i >= 0; i--) begin
      ex(9'h100);
      u_master.send(d[i*8 +: 8]);
    end
    if (stp)
      u_master.stop();
  endtask
  task automatic xr(input logic [6:0] a, input int n, input logic [127:0] d);
    u_master.start();
    ex(9'h100);
    u_master.send({a, 1'b1});
    for (int i = n - 1; i >= 0; i--) begin
      ex({1'b0, d[i*8 +: 8]});
      u_master.recv(i != 0);
    end
    u_master.stop();
  endtask
  always @(res_stb)
    if ($time > 0)
      check({23'h000000, res_val},
            expq.size() ? expq.pop_front() : 32'hffffffff);
  // looked at mid-cycle, where the one-cycle pulse stands settled
  always @(negedge core_clk)
    if (pull_start === 1'b1)
      check({6'h00, pull_value_word},
            pullq.size() ? {6'h00, pullq.pop_front()} : 32'hffffffff);
  always @(posedge stuck) begin
    mismatches++;
    give_verdict();
  end
  initial begin
    #3000000;
    mismatches++;
    give_verdict();
  end
  initial begin
    logic [6:0] own;
    logic [15:0] lo, lo2, rg;
    logic [9:0] up;
    repeat (5) @(posedge core_clk);
    #2 sys_rst = 1'b0;
    repeat (8) @(posedge core_clk);
    #7;
    check({pull_value_word, pull_range}, 32'h0);
    check({scl_oe_n, sda_oe_n}, 32'h3);
    own = 7'h6a;
    xr(own, 2, 128'h0);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      #2 {sel_hi, sel_lo} = k[1:0];
      lfsr = nxt(lfsr);
      own = {3'b110, k[1], 1'b0, k[0], 1'b0};
      u_master.start();
      ex(9'h101);
      u_master.send({~own[6], lfsr[5:0], 1'b0});
      u_master.stop();
      xw(own, 8'h02, 2, {112'h0, lfsr[31:16]}, 1'b1);
      check(pull_range, lfsr[19:16]);
    end
    lfsr = nxt(lfsr);
    lo = lfsr[15:0];
    up = lfsr[25:16];
    lfsr = nxt(lfsr);
    rg = lfsr[15:0];
    pullq.push_back({up, lo});
    // later words arrive while the pull waits, so the buffer fills up
    xw(own, 8'h00, 10, {lo, lfsr[31:26], up, rg, 32'hffffffff}, 1'b1);
    xw(own, 8'h00, 0, 128'h0, 1'b0);
    xr(own, 6, {lo, 6'h00, up, 12'h000, rg[3:0]});
    lfsr = nxt(lfsr);
    lo2 = lfsr[15:0];
    xw(own, 8'hff, 4, {lfsr[31:16], lo2}, 1'b1);
    check(pull_value_word, {up, lo});
    xr(own, 2, {6'h00, up});
    xw(own, 8'h02, 1, 128'h0ff, 1'b1);
    xw(own, 8'hff, 0, 128'h0, 1'b0);
    xr(own, 8, {16'h0000, lo2, 6'h00, up, 12'h000, rg[3:0]});
    repeat (20) @(posedge core_clk);
    check(expq.size() + pullq.size(), 32'h0);
    give_verdict();
  end
endmodule
